// ===== rtl/egfs_pkg.sv
// Package: register map, field layout and reset values of the bank.
`default_nettype none
package egfs_pkg;
  // ---------------------------------------------------------------
  // Register addresses
  // ---------------------------------------------------------------
  localparam logic [8:0] BANK_BASE     = 9'h0c0;
  localparam logic [8:0] OFS_TS_INTEG  = 9'h00b;
  localparam logic [8:0] OFS_AGAIN     = 9'h00c;
  localparam logic [8:0] OFS_DGAIN     = 9'h00d;
  localparam logic [8:0] OFS_SYNC      = 9'h00e;

  // ---------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------
  localparam logic [15:0] RST_TS_INTEG = 16'h0000;
  localparam logic [15:0] RST_AGAIN    = 16'h01e2;
  localparam logic [15:0] RST_DGAIN    = 16'h0080;
  localparam logic [15:0] RST_SYNC     = 16'h033f;

  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int AMP1_LSB   = 0;
  localparam int AMP1_W     = 2;
  localparam int AMP2_LSB   = 5;
  localparam int AMP2_W     = 4;
  localparam int GDLY_BIT   = 13;
  localparam int DGAIN_W    = 12;
  localparam int HOLD_LINE  = 0;
  localparam int HOLD_DARK  = 1;
  localparam int HOLD_FILL  = 2;
  localparam int HOLD_INTEG = 3;
  localparam int HOLD_AMP   = 4;
  localparam int HOLD_WIN   = 5;
  localparam int BLANK_WIN  = 8;
  localparam int BLANK_DEC  = 9;

  // Writable bits of each register; the rest read as zero.
  localparam logic [15:0] MASK_TS_INTEG = 16'hffff;
  localparam logic [15:0] MASK_AGAIN    = 16'h21e3;
  localparam logic [15:0] MASK_DGAIN    = 16'h0fff;
  localparam logic [15:0] MASK_SYNC     = 16'h033f;

  // ---------------------------------------------------------------
  // Widths of the external parameters handled here
  // ---------------------------------------------------------------
  localparam int LINE_W = 8;
  localparam int DARK_W = 8;
  localparam int FILL_W = 12;
  localparam int WIN_W  = 8;
  localparam int DEC_W  = 2;

  // Smallest divider value; zero is treated as one tick per clock.
  localparam logic [15:0] TICK_DIV_MIN = 16'h0001;
endpackage
`default_nettype wire

// ===== rtl/egfs_frame_hold.sv
// Module: one shadow copy loaded at frame start or at once.
`default_nettype none
module egfs_frame_hold #(
  parameter int        WIDTH = 8,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  // Clock and reset
  input  wire logic             clk_sys,
  input  wire logic             rst_n,
  input  wire logic             ce,
  // Control
  input  wire logic             frame_start,
  input  wire logic             hold_en,
  // Data
  input  wire logic [WIDTH-1:0] value_in,
  output logic      [WIDTH-1:0] value_out
);
  logic [WIDTH-1:0] shadow_r;
  logic [WIDTH-1:0] shadow_nxt;

  always_comb begin
    shadow_nxt = shadow_r;
    // Downstream only ever sees this copy, never the written value.
    if (!hold_en || frame_start) begin
      shadow_nxt = value_in;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      shadow_r <= RST_VAL;
    end else if (ce) begin
      shadow_r <= shadow_nxt;
    end
  end

  assign value_out = shadow_r;
endmodule
`default_nettype wire

// ===== rtl/egfs_regs.sv
// Module: exposure, gain and frame-update register bank with shadows.
`default_nettype none
// How it works
// - Sixteen-bit third-slope integration time, used in global shutter only.
// - Gain-delay bit set postpones new gain by one extra frame while the amplification hold flag is set.
// - Line readout length hold flag: apply at frame start, else at once.
// - Dark row hold flag: apply at frame start, else at once.
// - Filler row hold flag: apply at frame start, else at once.
// - Integration hold flag: apply exposure at frame start, else at once.
// - Amplification hold flag: gain changes at frame start, else at once.
// - Window hold flag: region selection at frame start, else at once.
// - Blank first frame after region selection changes when enabled.
// - Blank first frame after decimation change when enabled; always in rolling shutter.
// - Global shutter exposure durations counted in divider units of exposure_tick_div clocks each.
module egfs_regs (
  // Clock, reset and clock enable
  input  wire logic                          clk_sys,
  input  wire logic                          rst_n,
  input  wire logic                          ce,
  // Register port from the serial configuration decoder
  input  wire logic [8:0]                    cfg_addr,
  input  wire logic                          cfg_wr_en,
  input  wire logic [15:0]                   cfg_wdata,
  input  wire logic                          cfg_rd_en,
  output logic      [15:0]                   cfg_rdata,
  // Sequencer status
  input  wire logic                          frame_start,
  input  wire logic                          global_shutter,
  input  wire logic [15:0]                   exposure_tick_div,
  // Written values held in other registers of the bank
  input  wire logic [egfs_pkg::LINE_W-1:0]   rolling_line_readout_length,
  input  wire logic [egfs_pkg::DARK_W-1:0]   dark_rows_req,
  input  wire logic [egfs_pkg::FILL_W-1:0]   filler_rows_req,
  input  wire logic [egfs_pkg::WIN_W-1:0]    window_select_req,
  input  wire logic [egfs_pkg::DEC_W-1:0]    decimation_mode_req,
  // Applied values for readout and analog logic
  output logic      [egfs_pkg::LINE_W-1:0]   line_length_applied,
  output logic      [egfs_pkg::DARK_W-1:0]   dark_rows_applied,
  output logic      [egfs_pkg::FILL_W-1:0]   filler_rows_applied,
  output logic      [egfs_pkg::WIN_W-1:0]    window_select_applied,
  output logic      [15:0]                   third_slope_integration_time,
  output logic      [egfs_pkg::AMP1_W-1:0]   analog_amp_first_step,
  output logic      [egfs_pkg::AMP2_W-1:0]   analog_amp_second_step,
  output logic      [egfs_pkg::DGAIN_W-1:0]  digital_amp_factor,
  output logic                               exposure_tick,
  output logic                               frame_blank
);
  import egfs_pkg::*;

  // ---------------------------------------------------------------
  // Register file
  // ---------------------------------------------------------------
  logic [15:0] ts_integ_r;
  logic [15:0] ts_integ_nxt;
  logic [15:0] again_r;
  logic [15:0] again_nxt;
  logic [15:0] dgain_r;
  logic [15:0] dgain_nxt;
  logic [15:0] sync_r;
  logic [15:0] sync_nxt;
  logic [15:0] rdata_r;
  logic [15:0] rdata_nxt;
  logic [8:0]  ofs;

  assign ofs = cfg_addr - BANK_BASE;

  always_comb begin
    ts_integ_nxt = ts_integ_r;
    again_nxt    = again_r;
    dgain_nxt    = dgain_r;
    sync_nxt     = sync_r;
    rdata_nxt    = rdata_r;
    if (cfg_wr_en) begin
      unique case (ofs)
        OFS_TS_INTEG: ts_integ_nxt = cfg_wdata & MASK_TS_INTEG;
        OFS_AGAIN:    again_nxt    = cfg_wdata & MASK_AGAIN;
        OFS_DGAIN:    dgain_nxt    = cfg_wdata & MASK_DGAIN;
        OFS_SYNC:     sync_nxt     = cfg_wdata & MASK_SYNC;
        default:      ;
      endcase
    end
    // Unmapped offsets read as zero so a stray read never looks valid.
    if (cfg_rd_en) begin
      unique case (ofs)
        OFS_TS_INTEG: rdata_nxt = ts_integ_r;
        OFS_AGAIN:    rdata_nxt = again_r;
        OFS_DGAIN:    rdata_nxt = dgain_r;
        OFS_SYNC:     rdata_nxt = sync_r;
        default:      rdata_nxt = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      ts_integ_r <= RST_TS_INTEG;
      again_r    <= RST_AGAIN;
      dgain_r    <= RST_DGAIN;
      sync_r     <= RST_SYNC;
      rdata_r    <= 16'h0000;
    end else if (ce) begin
      ts_integ_r <= ts_integ_nxt;
      again_r    <= again_nxt;
      dgain_r    <= dgain_nxt;
      sync_r     <= sync_nxt;
      rdata_r    <= rdata_nxt;
    end
  end

  assign cfg_rdata = rdata_r;

  // ---------------------------------------------------------------
  // Frame-synchronised shadows of outside parameters
  // ---------------------------------------------------------------
  egfs_frame_hold #(.WIDTH(LINE_W), .RST_VAL('0)) u_hold_line (
    .clk_sys     (clk_sys),
    .rst_n       (rst_n),
    .ce          (ce),
    .frame_start (frame_start),
    .hold_en     (sync_r[HOLD_LINE]),
    .value_in    (rolling_line_readout_length),
    .value_out   (line_length_applied)
  );

  egfs_frame_hold #(.WIDTH(DARK_W), .RST_VAL('0)) u_hold_dark (
    .clk_sys     (clk_sys),
    .rst_n       (rst_n),
    .ce          (ce),
    .frame_start (frame_start),
    .hold_en     (sync_r[HOLD_DARK]),
    .value_in    (dark_rows_req),
    .value_out   (dark_rows_applied)
  );

  egfs_frame_hold #(.WIDTH(FILL_W), .RST_VAL('0)) u_hold_fill (
    .clk_sys     (clk_sys),
    .rst_n       (rst_n),
    .ce          (ce),
    .frame_start (frame_start),
    .hold_en     (sync_r[HOLD_FILL]),
    .value_in    (filler_rows_req),
    .value_out   (filler_rows_applied)
  );

  egfs_frame_hold #(.WIDTH(WIN_W), .RST_VAL('0)) u_hold_win (
    .clk_sys     (clk_sys),
    .rst_n       (rst_n),
    .ce          (ce),
    .frame_start (frame_start),
    .hold_en     (sync_r[HOLD_WIN]),
    .value_in    (window_select_req),
    .value_out   (window_select_applied)
  );

  // ---------------------------------------------------------------
  // Exposure shadow
  // ---------------------------------------------------------------
  logic [15:0] ts_shadow;

  egfs_frame_hold #(.WIDTH(16), .RST_VAL(RST_TS_INTEG)) u_hold_integ (
    .clk_sys     (clk_sys),
    .rst_n       (rst_n),
    .ce          (ce),
    .frame_start (frame_start),
    .hold_en     (sync_r[HOLD_INTEG]),
    .value_in    (ts_integ_r),
    .value_out   (ts_shadow)
  );

  // ---------------------------------------------------------------
  // Gain shadows with optional one-frame delay
  // ---------------------------------------------------------------
  // The staged copy lets gain line up with exposure, which itself lands
  // one frame late; the direct path applies at the next frame start.
  // Packed word: digital factor over second step over first step.
  localparam int GAIN_W = AMP1_W + AMP2_W + DGAIN_W;

  logic [GAIN_W-1:0] gain_stage_r;
  logic [GAIN_W-1:0] gain_stage_nxt;
  logic [GAIN_W-1:0] gain_appl_r;
  logic [GAIN_W-1:0] gain_appl_nxt;
  logic [GAIN_W-1:0] gain_wr;

  assign gain_wr = {dgain_r[DGAIN_W-1:0],
                    again_r[AMP2_LSB +: AMP2_W],
                    again_r[AMP1_LSB +: AMP1_W]};

  always_comb begin
    gain_stage_nxt = gain_stage_r;
    gain_appl_nxt  = gain_appl_r;
    if (!sync_r[HOLD_AMP]) begin
      // Without frame hold the delay has nothing to align to.
      gain_stage_nxt = gain_wr;
      gain_appl_nxt  = gain_wr;
    end else if (frame_start) begin
      gain_stage_nxt = gain_wr;
      if (again_r[GDLY_BIT]) begin
        gain_appl_nxt = gain_stage_r;
      end else begin
        gain_appl_nxt = gain_wr;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      gain_stage_r <= {RST_DGAIN[DGAIN_W-1:0],
                       RST_AGAIN[AMP2_LSB +: AMP2_W],
                       RST_AGAIN[AMP1_LSB +: AMP1_W]};
      gain_appl_r  <= {RST_DGAIN[DGAIN_W-1:0],
                       RST_AGAIN[AMP2_LSB +: AMP2_W],
                       RST_AGAIN[AMP1_LSB +: AMP1_W]};
    end else if (ce) begin
      gain_stage_r <= gain_stage_nxt;
      gain_appl_r  <= gain_appl_nxt;
    end
  end

  assign analog_amp_first_step  = gain_appl_r[AMP1_W-1:0];
  assign analog_amp_second_step = gain_appl_r[AMP1_W +: AMP2_W];
  assign digital_amp_factor     = gain_appl_r[AMP1_W+AMP2_W +: DGAIN_W];

  // ---------------------------------------------------------------
  // Exposure time output and tick divider
  // ---------------------------------------------------------------
  logic [15:0] ts_out_r;
  logic [15:0] ts_out_nxt;
  logic [15:0] tick_cnt_r;
  logic [15:0] tick_cnt_nxt;
  logic        tick_r;
  logic        tick_nxt;
  logic [15:0] tick_div;

  // A zero divider would wrap to one tick per 65536 clocks; treat it as the smallest unit.
  assign tick_div = (exposure_tick_div < TICK_DIV_MIN) ?
                    TICK_DIV_MIN : exposure_tick_div;

  always_comb begin
    // Rolling shutter has no third slope, so the value is withheld.
    ts_out_nxt   = global_shutter ? ts_shadow : 16'h0000;
    tick_cnt_nxt = tick_cnt_r;
    tick_nxt     = 1'b0;
    if (!global_shutter || frame_start) begin
      tick_cnt_nxt = 16'h0000;
    end else if (tick_cnt_r >= tick_div - 16'h0001) begin
      tick_cnt_nxt = 16'h0000;
      tick_nxt     = 1'b1;
    end else begin
      tick_cnt_nxt = tick_cnt_r + 16'h0001;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      ts_out_r   <= 16'h0000;
      tick_cnt_r <= 16'h0000;
      tick_r     <= 1'b0;
    end else if (ce) begin
      ts_out_r   <= ts_out_nxt;
      tick_cnt_r <= tick_cnt_nxt;
      tick_r     <= tick_nxt;
    end
  end

  assign third_slope_integration_time = ts_out_r;
  assign exposure_tick                = tick_r & ce;

  // ---------------------------------------------------------------
  // Frame blanking after window or decimation changes
  // ---------------------------------------------------------------
  logic [WIN_W-1:0] win_prev_r;
  logic [DEC_W-1:0] dec_appl_r;
  logic [DEC_W-1:0] dec_appl_nxt;
  logic             blank_pend_r;
  logic             blank_pend_nxt;
  logic             blank_r;
  logic             blank_nxt;
  logic             win_changed;
  logic             dec_changed;

  assign win_changed = (window_select_applied != win_prev_r);
  assign dec_changed = frame_start && (decimation_mode_req != dec_appl_r);

  always_comb begin
    dec_appl_nxt   = frame_start ? decimation_mode_req : dec_appl_r;
    blank_pend_nxt = blank_pend_r;
    blank_nxt      = blank_r;
    if (frame_start) begin
      blank_nxt      = blank_pend_r;
      blank_pend_nxt = 1'b0;
    end
    // A change seen in the frame-start cycle belongs to the new frame,
    // so setting wins over the clear just above.
    if (win_changed && sync_r[BLANK_WIN]) begin
      blank_pend_nxt = 1'b1;
    end
    if (dec_changed && (sync_r[BLANK_DEC] || !global_shutter)) begin
      blank_nxt = 1'b1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      win_prev_r   <= '0;
      dec_appl_r   <= '0;
      blank_pend_r <= 1'b0;
      blank_r      <= 1'b0;
    end else if (ce) begin
      win_prev_r   <= window_select_applied;
      dec_appl_r   <= dec_appl_nxt;
      blank_pend_r <= blank_pend_nxt;
      blank_r      <= blank_nxt;
    end
  end

  assign frame_blank = blank_r;
endmodule
`default_nettype wire

// ===== tb/egfs_regs_asserts.sv
// Checker: frame-sync timing relations of the register bank outputs.
`default_nettype none
module egfs_regs_asserts (
  // Clock and reset
  input wire logic        clk_sys,
  input wire logic        rst_n,
  input wire logic        ce,
  // Register writes
  input wire logic [8:0]  cfg_addr,
  input wire logic        cfg_wr_en,
  input wire logic [15:0] cfg_wdata,
  // Sequencer and requested values
  input wire logic        frame_start,
  input wire logic        global_shutter,
  input wire logic [15:0] exposure_tick_div,
  input wire logic [7:0]  dark_rows_req,
  input wire logic [11:0] filler_rows_req,
  input wire logic [1:0]  decimation_mode_req,
  // Applied values
  input wire logic [7:0]  line_length_applied,
  input wire logic [7:0]  dark_rows_applied,
  input wire logic [11:0] filler_rows_applied,
  input wire logic [7:0]  window_select_applied,
  input wire logic [15:0] third_slope_integration_time,
  input wire logic [1:0]  analog_amp_first_step,
  input wire logic        exposure_tick,
  input wire logic        frame_blank
);
  timeunit 1ns;
  timeprecision 1ps;
  import egfs_pkg::*;
  // ---------------------------------------------------------------
  // Mirror of written flags and gain, and the last latched decimation
  // ---------------------------------------------------------------
  logic [15:0] sync_r, sync_nxt, gain_r, gain_nxt;
  logic [1:0]  dec_r, dec_nxt;
  always_comb begin
    sync_nxt = sync_r;
    gain_nxt = gain_r;
    dec_nxt  = dec_r;
    if (ce && cfg_wr_en && cfg_addr == 9'h0ce) begin
      sync_nxt = cfg_wdata & MASK_SYNC;
    end
    if (ce && cfg_wr_en && cfg_addr == 9'h0cc) begin
      gain_nxt = cfg_wdata & MASK_AGAIN;
    end
    if (ce && frame_start) begin
      dec_nxt = decimation_mode_req;
    end
  end
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      sync_r <= RST_SYNC;
      gain_r <= RST_AGAIN;
      dec_r  <= 2'h0;
    end else begin
      sync_r <= sync_nxt;
      gain_r <= gain_nxt;
      dec_r  <= dec_nxt;
    end
  end
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  property p_ts_roll;
    ce && !global_shutter |=> third_slope_integration_time == 16'h0000;
  endproperty
  property p_line_hold;
    ce && !frame_start && sync_r[HOLD_LINE] |=> $stable(line_length_applied);
  endproperty
  property p_dark_free;
    ce && !sync_r[HOLD_DARK] |=> dark_rows_applied == $past(dark_rows_req);
  endproperty
  property p_fill_fs;
    ce && frame_start |=> filler_rows_applied == $past(filler_rows_req);
  endproperty
  property p_amp_free;
    ce && !sync_r[HOLD_AMP] |=> analog_amp_first_step == $past(gain_r[1:0]);
  endproperty
  property p_win_hold;
    ce && !frame_start && sync_r[HOLD_WIN] |=> $stable(window_select_applied);
  endproperty
  property p_tick;
    exposure_tick && exposure_tick_div == 16'h0004 |=> !exposure_tick [*3];
  endproperty
  property p_dec_blank;
    ce && frame_start && !global_shutter && decimation_mode_req != dec_r
      |=> frame_blank;
  endproperty
  a_ts_roll: assert property (p_ts_roll)
    else $error("third slope time not zero in rolling mode");
  a_line_hold: assert property (p_line_hold)
    else $error("line length moved between frame starts");
  a_dark_free: assert property (p_dark_free)
    else $error("dark rows did not follow while free");
  a_fill_fs: assert property (p_fill_fs)
    else $error("filler rows not loaded at frame start");
  a_amp_free: assert property (p_amp_free)
    else $error("gain did not follow while free");
  a_win_hold: assert property (p_win_hold)
    else $error("window selection moved between frame starts");
  a_tick: assert property (p_tick)
    else $error("exposure tick too early");
  a_dec_blank: assert property (p_dec_blank)
    else $error("decimation change not blanked in rolling mode");
  c_blank: cover property (frame_blank);
  c_tick: cover property (exposure_tick);
  c_free: cover property (!sync_r[HOLD_AMP]);
endmodule
`default_nettype wire

// ===== tb/egfs_host.sv
// Partner: host side of the configuration register port.
`default_nettype none
module egfs_host (
  // Clock
  input  wire logic        clk_sys,
  // Register port
  output logic      [8:0]  cfg_addr,
  output logic             cfg_wr_en,
  output logic      [15:0] cfg_wdata,
  output logic             cfg_rd_en,
  input  wire logic [15:0] cfg_rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    cfg_addr  = 9'h000;
    cfg_wr_en = 1'b0;
    cfg_wdata = 16'h0000;
    cfg_rd_en = 1'b0;
  end
  // Idle lines are inverted so a stale word is never taken as live.
  task automatic wr(input logic [8:0] a, input logic [15:0] d);
    @(negedge clk_sys);
    cfg_addr = a;
    cfg_wdata = d;
    cfg_wr_en = 1'b1;
    @(negedge clk_sys);
    cfg_wr_en = 1'b0;
    cfg_wdata = ~d;
    cfg_addr = ~a;
  endtask
  task automatic rd(input logic [8:0] a, output logic [15:0] d);
    @(negedge clk_sys);
    cfg_addr = a;
    cfg_rd_en = 1'b1;
    @(negedge clk_sys);
    cfg_rd_en = 1'b0;
    cfg_addr = ~a;
    d = cfg_rdata;
  endtask
endmodule
`default_nettype wire

// ===== tb/test_exposure_gain_frame_sync_regs.sv
// Testbench: scenarios for the exposure, gain and frame-sync bank.
`default_nettype none
module test_exposure_gain_frame_sync_regs;
  timeunit 1ns;
  timeprecision 1ps;
  import egfs_pkg::*;
  logic        clk_sys = 1'b0;
  logic        rst_n, ce, frame_start, global_shutter;
  logic        cfg_wr_en, cfg_rd_en, exposure_tick, frame_blank;
  logic [8:0]  cfg_addr;
  logic [15:0] cfg_wdata, cfg_rdata, exposure_tick_div, rv;
  logic [15:0] third_slope_integration_time;
  logic [7:0]  rolling_line_readout_length, dark_rows_req;
  logic [7:0]  window_select_req, line_length_applied;
  logic [7:0]  dark_rows_applied, window_select_applied;
  logic [11:0] filler_rows_req, filler_rows_applied, digital_amp_factor;
  logic [1:0]  decimation_mode_req, analog_amp_first_step;
  logic [3:0]  analog_amp_second_step;
  int          err_total = 0;
  int          tests_run = 0;
  egfs_regs dut (.*);
  egfs_host u_host (.*);
  always #2 clk_sys = ~clk_sys;
  // ---------------------------------------------------------------
  // Shared tasks
  // ---------------------------------------------------------------
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_total++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic final_report;
    $display("checks=%0d mismatches=%0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge clk_sys);
  endtask
  task automatic fs;
    @(negedge clk_sys);
    frame_start = 1'b1;
    @(negedge clk_sys);
    frame_start = 1'b0;
  endtask
  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic t_regs;
    logic [15:0] rst_v [4];
    logic [15:0] msk [4];
    rst_v = '{RST_TS_INTEG, RST_AGAIN, RST_DGAIN, RST_SYNC};
    msk = '{MASK_TS_INTEG, MASK_AGAIN, MASK_DGAIN, MASK_SYNC};
    chk(16'(analog_amp_first_step), 16'h0002);
    chk(16'(analog_amp_second_step), 16'h000f);
    chk(16'(digital_amp_factor), 16'h0080);
    for (int i = 0; i < 4; i++) begin
      u_host.rd(9'h0cb + 9'(i), rv);
      chk(rv, rst_v[i]);
      u_host.wr(9'h0cb + 9'(i), 16'hffff);
      u_host.rd(9'h0cb + 9'(i), rv);
      chk(rv, msk[i]);
      u_host.wr(9'h0cb + 9'(i), rst_v[i]);
    end
    u_host.wr(9'h0cf, 16'hffff);
    u_host.rd(9'h0cf, rv);
    chk(rv, 16'h0000);
    ce = 1'b0;
    u_host.wr(9'h0cb, 16'h5555);
    ce = 1'b1;
    u_host.rd(9'h0cb, rv);
    chk(rv, RST_TS_INTEG);
  endtask
  task automatic t_integ;
    u_host.wr(9'h0cb, 16'h1234);
    cyc(3);
    chk(third_slope_integration_time, 16'h0000);
    fs();
    cyc(1);
    chk(third_slope_integration_time, 16'h1234);
    global_shutter = 1'b0;
    cyc(2);
    chk(third_slope_integration_time, 16'h0000);
  endtask
  task automatic t_gain;
    u_host.wr(9'h0cc, 16'h2061);
    u_host.wr(9'h0cd, 16'h0abc);
    fs();
    cyc(1);
    chk(16'(analog_amp_first_step), 16'h0002);
    fs();
    cyc(1);
    chk(16'(analog_amp_first_step), 16'h0001);
    chk(16'(analog_amp_second_step), 16'h0003);
    chk(16'(digital_amp_factor), 16'h0abc);
    u_host.wr(9'h0cc, 16'h0003);
    cyc(3);
    chk(16'(analog_amp_first_step), 16'h0001);
    fs();
    cyc(1);
    chk(16'(analog_amp_first_step), 16'h0003);
  endtask
  task automatic t_free;
    u_host.wr(9'h0ce, 16'h0300);
    rolling_line_readout_length = 8'h5a;
    dark_rows_req = 8'h33;
    filler_rows_req = 12'h7e1;
    window_select_req = 8'h81;
    u_host.wr(9'h0cc, 16'h0002);
    cyc(2);
    chk(16'(line_length_applied), 16'h005a);
    chk(16'(dark_rows_applied), 16'h0033);
    chk(16'(filler_rows_applied), 16'h07e1);
    chk(16'(window_select_applied), 16'h0081);
    chk(16'(analog_amp_first_step), 16'h0002);
    u_host.wr(9'h0ce, RST_SYNC);
    rolling_line_readout_length = 8'ha5;
    filler_rows_req = 12'h18e;
    window_select_req = 8'h42;
    cyc(3);
    chk(16'(line_length_applied), 16'h005a);
    chk(16'(filler_rows_applied), 16'h07e1);
    chk(16'(window_select_applied), 16'h0081);
    fs();
    chk(16'(frame_blank), 16'h0001);
    chk(16'(line_length_applied), 16'h00a5);
  endtask
  task automatic t_blank;
    fs();
    chk(16'(frame_blank), 16'h0001);
    fs();
    chk(16'(frame_blank), 16'h0000);
    u_host.wr(9'h0ce, 16'h023f);
    window_select_req = 8'h01;
    fs();
    fs();
    chk(16'(frame_blank), 16'h0000);
    decimation_mode_req = 2'h2;
    fs();
    chk(16'(frame_blank), 16'h0001);
    global_shutter = 1'b1;
    u_host.wr(9'h0ce, 16'h003f);
    decimation_mode_req = 2'h1;
    fs();
    chk(16'(frame_blank), 16'h0000);
    u_host.wr(9'h0ce, RST_SYNC);
    decimation_mode_req = 2'h3;
    fs();
    chk(16'(frame_blank), 16'h0001);
  endtask
  task automatic t_tick;
    int k;
    int first;
    first = -1;
    for (k = 0; k < 40; k++) begin
      @(negedge clk_sys);
      if (exposure_tick === 1'b1) begin
        if (first >= 0) break;
        first = k;
      end
    end
    if (k == 40) begin
      err_total++;
      final_report();
    end else begin
      chk(16'(k - first), 16'h0004);
    end
  endtask
  initial begin
    rst_n = 1'b0;
    ce = 1'b1;
    frame_start = 1'b0;
    global_shutter = 1'b1;
    exposure_tick_div = 16'h0004;
    rolling_line_readout_length = 8'h00;
    dark_rows_req = 8'h00;
    filler_rows_req = 12'h000;
    window_select_req = 8'h00;
    decimation_mode_req = 2'h0;
    repeat (16) @(negedge clk_sys);
    rst_n = 1'b1;
    t_regs();
    t_integ();
    t_gain();
    t_free();
    t_blank();
    t_tick();
    final_report();
  end
endmodule
bind egfs_regs egfs_regs_asserts u_chk (.*);
`default_nettype wire
